// *** logic/wrc_consts.svh ***
// constants for the watchdog and reset control block
`ifndef WRC_CONSTS_SVH
`define WRC_CONSTS_SVH

// register offsets on the plain register port
`define WRC_OFF_WDT_CTRL   4'h0
`define WRC_OFF_NOISE_KEY  4'h1
`define WRC_OFF_CAUSE      4'h2
`define WRC_OFF_BOR_LEVEL  4'h3
`define WRC_OFF_FLASH_CTL2 4'h4
`define WRC_OFF_MODE       4'h5

// reset values
`define WRC_RST_WDT_CTRL   8'h53
`define WRC_RST_NOISE_KEY  8'h55
`define WRC_RST_BOR_LEVEL  8'h55
`define WRC_RST_CAUSE      4'h0

// key patterns
`define WRC_WDT_KEY_A      5'h15
`define WRC_WDT_KEY_B      5'h0a
`define WRC_NOISE_KEY_A    8'h55
`define WRC_NOISE_KEY_B    8'haa
`define WRC_BOR_2V1        8'h55
`define WRC_BOR_2V55       8'h33
`define WRC_BOR_3V15       8'h99
`define WRC_BOR_3V8        8'haa
`define WRC_FLASH_RST_VAL  8'h55

// field positions
`define WRC_KEY_MSB        7
`define WRC_KEY_LSB        3
`define WRC_SEL_MSB        2
`define WRC_FLAG_KEY_RST   3
`define WRC_FLAG_BOR       2
`define WRC_FLAG_BOR_KEY   1
`define WRC_FLAG_WDT_KEY   0

// timing: low-speed clock, key and filter delays in low-speed periods, reset hold in ref_clk cycles
`define WRC_REF_HZ         100000000
`define WRC_LOW_SPEED_RC_OSCILLATOR_HZ        32000
`define WRC_LOW_SPEED_RC_OSCILLATOR_DIV       (`WRC_REF_HZ / `WRC_LOW_SPEED_RC_OSCILLATOR_HZ)
`define WRC_KEY_DELAY_LP   4
`define WRC_BOR_FILTER_LP  8
`define WRC_RESET_HOLD     16

`endif

// *** logic/wrc_pkg.sv ***
// types for the watchdog and reset control block
package wrc_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wrc_req_t;

  typedef struct packed {
    logic key_rst;
    logic bor;
    logic bor_key;
    logic wdt_key;
  } wrc_cause_t;

  typedef enum logic [1:0] {
    WRC_RUN   = 2'b00,
    WRC_DELAY = 2'b01,
    WRC_HOLD  = 2'b10
  } wrc_state_t;

endpackage : wrc_pkg

// *** logic/wrc_top.sv ***
// watchdog, key-protected resets, brownout filter and reset-cause flags
`timescale 1ns/1ps
`default_nettype none
`include "wrc_consts.svh"

// Operation
// - watchdog counts only while its key field holds 10101B or 01010B
// - any other watchdog key resets the device after the key delay
// - watchdog key field loads 01010B at power-up, watchdog enabled
// - overflow while running resets device and sets the expired flag
// - overflow in sleep/idle sets expired flag, clears only pc and sp
// - invalid key write, clear instruction or halt clears the count
// - timeout is low-speed clock divided by 2^8 up to 2^18
// - noise key 55H or AAH is harmless; other values reset after delay
// - noise key reset sets flag bit 3, cleared only by software
// - upper four flag register bits read as zero
// - power-on clears pc and sets port data and direction high
// - brownout active in fast/slow, disabled in sleep or idle
// - brownout resets only if low supply outlasts the filter time
// - brownout code selects one of four thresholds
// - genuine brownout reset keeps the brownout level register
// - undefined level code resets after delay, restores power-on value
// - brownout level register loads 01010101B at power-on
// - genuine brownout sets flag bit 2, cleared only by software
// - undefined level code sets flag bit 1, cleared only by software
// - writing 55H to second flash control register resets device
// - invalid watchdog key reset sets flag bit 0, software clears
// - period select 000..111 picks 2^8,10,12,14,15,16,17,18
// - watchdog clocked from the about 32kHz low-speed rc clock
module wrc_top
  import wrc_pkg::*;
#(
  parameter int unsigned LOW_SPEED_RC_OSCILLATOR_DIV      = `WRC_LOW_SPEED_RC_OSCILLATOR_DIV,
  parameter int unsigned KEY_DELAY_LP  = `WRC_KEY_DELAY_LP,
  parameter int unsigned BOR_FILTER_LP = `WRC_BOR_FILTER_LP,
  parameter int unsigned RESET_HOLD    = `WRC_RESET_HOLD
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       clear_watchdog_instruction_instr,
  input  wire logic       halt_instr,
  input  wire logic       low_supply,
  output logic            sys_rst_n,
  output logic            pc_sp_clear,
  output logic            wdt_expired,
  output logic      [1:0] bor_threshold,
  output logic            port_init
);

  // ------------------------------------------------------------
  // register port decode
  // ------------------------------------------------------------
  wrc_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  wire wr_wdt   = req.wr && req.addr == `WRC_OFF_WDT_CTRL;
  wire wr_noise = req.wr && req.addr == `WRC_OFF_NOISE_KEY;
  wire wr_cause = req.wr && req.addr == `WRC_OFF_CAUSE;
  wire wr_bor   = req.wr && req.addr == `WRC_OFF_BOR_LEVEL;
  wire wr_flash = req.wr && req.addr == `WRC_OFF_FLASH_CTL2;
  wire wr_mode  = req.wr && req.addr == `WRC_OFF_MODE;

  function automatic logic wdt_key_ok(input logic [7:0] r);
    wdt_key_ok = r[`WRC_KEY_MSB:`WRC_KEY_LSB] == `WRC_WDT_KEY_A ||
                 r[`WRC_KEY_MSB:`WRC_KEY_LSB] == `WRC_WDT_KEY_B;
  endfunction : wdt_key_ok

  function automatic logic bor_code_ok(input logic [7:0] c);
    bor_code_ok = c == `WRC_BOR_2V1 || c == `WRC_BOR_2V55 ||
                  c == `WRC_BOR_3V15 || c == `WRC_BOR_3V8;
  endfunction : bor_code_ok

  // ------------------------------------------------------------
  // state and software registers; only cause_q survives every internal reset
  // ------------------------------------------------------------
  logic [7:0] wdt_ctrl_q;
  logic [7:0] noise_key_q;
  logic [7:0] bor_level_q;
  logic [7:0] flash_ctl2_q;
  wrc_cause_t cause_q;
  logic       sleep_q;
  logic       int_rst;        // internal reset pulse
  logic       bor_key_restore;
  wrc_state_t state_q;

  wire wdt_key_bad   = !wdt_key_ok(wdt_ctrl_q);
  wire noise_key_bad = noise_key_q != `WRC_NOISE_KEY_A &&
                       noise_key_q != `WRC_NOISE_KEY_B;
  wire bor_code_bad  = !bor_code_ok(bor_level_q);

  // ------------------------------------------------------------
  // low-speed enable from ref_clk divider
  // ------------------------------------------------------------
  logic [$clog2(LOW_SPEED_RC_OSCILLATOR_DIV)-1:0] div_q;
  wire low_speed_rc_oscillator_tick = div_q == ($clog2(LOW_SPEED_RC_OSCILLATOR_DIV))'(LOW_SPEED_RC_OSCILLATOR_DIV - 1);

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      div_q <= '0;
    else
      div_q <= low_speed_rc_oscillator_tick ? '0 : div_q + 1'b1;

  // ------------------------------------------------------------
  // watchdog counter
  // ------------------------------------------------------------
  logic [18:0] wdt_cnt_q;
  logic [4:0]  tap;
  always_comb
  begin
    unique case (wdt_ctrl_q[`WRC_SEL_MSB:0])
      3'h0: tap = 5'd8;
      3'h1: tap = 5'd10;
      3'h2: tap = 5'd12;
      3'h3: tap = 5'd14;
      3'h4: tap = 5'd15;
      3'h5: tap = 5'd16;
      3'h6: tap = 5'd17;
      3'h7: tap = 5'd18;
    endcase
  end
  wire wdt_ovf   = wdt_cnt_q[tap] && state_q == WRC_RUN;
  wire wdt_clear = clear_watchdog_instruction_instr || halt_instr || wdt_key_bad ||
                   wdt_ovf || int_rst;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      wdt_cnt_q <= '0;
    else if (wdt_clear)
      wdt_cnt_q <= '0;
    else if (low_speed_rc_oscillator_tick && !wdt_key_bad)
      wdt_cnt_q <= wdt_cnt_q + 19'h1;

  // ------------------------------------------------------------
  // brownout filter, only in fast/slow
  // ------------------------------------------------------------
  logic [2:0] ls_sync_q;
  logic [$clog2(BOR_FILTER_LP+1)-1:0] bor_cnt_q;
  logic       ls_q;
  wire bor_fire = bor_cnt_q == ($clog2(BOR_FILTER_LP+1))'(BOR_FILTER_LP)
                  && low_speed_rc_oscillator_tick && ls_q && state_q == WRC_RUN;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      ls_sync_q <= '0;
      ls_q      <= 1'b0;
    end
    else
    begin
      ls_sync_q <= {ls_sync_q[1:0], low_supply};
      if (ls_sync_q[1] == ls_sync_q[2])
        ls_q <= ls_sync_q[2];
    end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      bor_cnt_q <= '0;
    else if (!ls_q || sleep_q || bor_code_bad)
      bor_cnt_q <= '0;
    else if (low_speed_rc_oscillator_tick && !bor_fire)
      bor_cnt_q <= bor_cnt_q + 1'b1;

  // ------------------------------------------------------------
  // key reset delay and reset sequencing
  // ------------------------------------------------------------
  wire any_key_bad = wdt_key_bad || noise_key_bad || bor_code_bad;
  logic [$clog2(KEY_DELAY_LP+1)-1:0] dly_q;
  logic [$clog2(RESET_HOLD+1)-1:0]   hold_q;
  wire dly_done = dly_q == ($clog2(KEY_DELAY_LP+1))'(KEY_DELAY_LP) &&
                  low_speed_rc_oscillator_tick;
  wire flash_rst = wr_flash && req.wdata == `WRC_FLASH_RST_VAL;
  wire wdt_full  = wdt_ovf && !sleep_q;
  wire start_rst = (state_q == WRC_DELAY && dly_done) || flash_rst ||
                   wdt_full || bor_fire;
  assign int_rst = start_rst;
  assign bor_key_restore = state_q == WRC_DELAY && dly_done && bor_code_bad;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      state_q <= WRC_HOLD;
      dly_q   <= '0;
      hold_q  <= '0;
    end
    else if (start_rst)
    begin
      state_q <= WRC_HOLD;
      hold_q  <= '0;
    end
    else
    begin
      unique case (state_q)
        WRC_RUN:
        begin
          dly_q <= '0;
          if (any_key_bad)
            state_q <= WRC_DELAY;
        end
        WRC_DELAY:
        begin
          if (!any_key_bad)
            state_q <= WRC_RUN;
          else if (low_speed_rc_oscillator_tick)
            dly_q <= dly_q + 1'b1;
        end
        WRC_HOLD:
        begin
          hold_q <= hold_q + 1'b1;
          if (hold_q == ($clog2(RESET_HOLD+1))'(RESET_HOLD - 1))
            state_q <= WRC_RUN;
        end
        default:
          state_q <= WRC_RUN;
      endcase
    end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  // key registers are not restored by key resets, so a latched bad
  // key would loop the reset; restore them when their own delay ends
  wire key_restore = state_q == WRC_DELAY && dly_done;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      wdt_ctrl_q   <= `WRC_RST_WDT_CTRL;
      noise_key_q  <= `WRC_RST_NOISE_KEY;
      bor_level_q  <= `WRC_RST_BOR_LEVEL;
      flash_ctl2_q <= '0;
      sleep_q      <= 1'b0;
    end
    else
    begin
      if (key_restore || wdt_full || flash_rst)
      begin
        wdt_ctrl_q  <= `WRC_RST_WDT_CTRL;
        noise_key_q <= `WRC_RST_NOISE_KEY;
      end
      else
      begin
        if (wr_wdt)
          wdt_ctrl_q <= req.wdata;
        if (wr_noise)
          noise_key_q <= req.wdata;
      end
      if (bor_key_restore || wdt_full || flash_rst)
        bor_level_q <= `WRC_RST_BOR_LEVEL;
      else if (wr_bor)
        bor_level_q <= req.wdata;
      flash_ctl2_q <= (start_rst) ? '0 :
                      (wr_flash ? req.wdata : flash_ctl2_q);
      if (halt_instr)
        sleep_q <= 1'b1;
      else if (start_rst || wdt_ovf || wr_mode)
        sleep_q <= wr_mode ? req.wdata[0] : 1'b0;
    end

  // ------------------------------------------------------------
  // sticky reset-cause flags: set wins over software clear
  // ------------------------------------------------------------
  wrc_cause_t cause_set;
  assign cause_set.key_rst = key_restore && noise_key_bad;
  assign cause_set.bor     = bor_fire;
  assign cause_set.bor_key = bor_key_restore;
  assign cause_set.wdt_key = key_restore && wdt_key_bad;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      cause_q <= `WRC_RST_CAUSE;
    else if (wr_cause)
      cause_q <= wrc_cause_t'(req.wdata[3:0] & cause_q) | cause_set;
    else
      cause_q <= cause_q | cause_set;

  // ------------------------------------------------------------
  // outputs and read data
  // ------------------------------------------------------------
  logic [7:0] rdata_d;
  always_comb
  begin
    unique case (req.addr)
      `WRC_OFF_WDT_CTRL:   rdata_d = wdt_ctrl_q;
      `WRC_OFF_NOISE_KEY:  rdata_d = noise_key_q;
      `WRC_OFF_CAUSE:      rdata_d = {4'h0, cause_q};
      `WRC_OFF_BOR_LEVEL:  rdata_d = bor_level_q;
      `WRC_OFF_FLASH_CTL2: rdata_d = flash_ctl2_q;
      `WRC_OFF_MODE:       rdata_d = {7'h0, sleep_q};
      default:             rdata_d = 8'h00;
    endcase
  end

  logic [1:0] thr_d;
  always_comb
  begin
    unique case (bor_level_q)
      `WRC_BOR_2V55: thr_d = 2'h1;
      `WRC_BOR_3V15: thr_d = 2'h2;
      `WRC_BOR_3V8:  thr_d = 2'h3;
      default:       thr_d = 2'h0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      reg_rdata     <= '0;
      sys_rst_n     <= 1'b0;
      pc_sp_clear   <= 1'b0;
      wdt_expired   <= 1'b0;
      bor_threshold <= '0;
      port_init     <= 1'b1;
    end
    else
    begin
      reg_rdata     <= req.rd ? rdata_d : 8'h00;
      sys_rst_n     <= !(state_q == WRC_HOLD || start_rst);
      pc_sp_clear   <= wdt_ovf && sleep_q;
      if (wdt_ovf)
        wdt_expired <= 1'b1;
      else if (clear_watchdog_instruction_instr || halt_instr)
        wdt_expired <= 1'b0;
      bor_threshold <= thr_d;
      port_init     <= state_q == WRC_HOLD && !wdt_ovf;
    end

endmodule : wrc_top

`default_nettype wire

// *** testbench/watchdog_and_reset_control_test.sv ***
// self-checking bench for the watchdog and reset control block
`timescale 1ns/1ps
`default_nettype none
`include "wrc_consts.svh"
module watchdog_and_reset_control_test;
  logic       ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       low_supply = 1'b0, kick_en = 1'b1, halt_req = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [1:0] bor_threshold;
  logic       clear_watchdog_instruction_instr, halt_instr, sys_rst_n, pc_sp_clear;
  logic       wdt_expired, port_init;
  int         fails = 0, checked = 0;
  logic [7:0] bor_codes [4] = '{8'h55, 8'h33, 8'h99, 8'haa};
  logic [3:0] bad_addr [3] = '{`WRC_OFF_WDT_CTRL, `WRC_OFF_NOISE_KEY,
                               `WRC_OFF_BOR_LEVEL};
  logic [7:0] bad_data [3] = '{8'hff, 8'h00, 8'h12};
  logic [7:0] bad_flag [3] = '{8'h01, 8'h08, 8'h02};
  logic [7:0] bad_rest [3] = '{8'h53, 8'h55, 8'h55};

  wrc_top #(.LOW_SPEED_RC_OSCILLATOR_DIV(4), .KEY_DELAY_LP(4), .BOR_FILTER_LP(8),
    .RESET_HOLD(16)) i_wrc_top (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .clear_watchdog_instruction_instr(clear_watchdog_instruction_instr),
    .halt_instr(halt_instr), .low_supply(low_supply),
    .sys_rst_n(sys_rst_n), .pc_sp_clear(pc_sp_clear),
    .wdt_expired(wdt_expired), .bor_threshold(bor_threshold),
    .port_init(port_init));
  wrc_core_model i_wrc_core_model (
    .ref_clk(ref_clk), .rst_n(rst_n), .core_run(sys_rst_n),
    .kick_en(kick_en), .halt_req(halt_req),
    .clear_watchdog_instruction_instr(clear_watchdog_instruction_instr), .halt_instr(halt_instr));

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  // --------
  // tasks
  // --------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rdc
  // watch n cycles for a device reset, then wait for its release
  task automatic expect_rst(input int n, input logic exp);
    logic seen;
    int   k;
    seen = 1'b0;
    for (k = 0; k < n && !seen; k++)
    begin
      @(posedge ref_clk);
      #1 seen = !sys_rst_n;
    end
    chk({7'h00, seen}, {7'h00, exp});
    if (seen)
      low_supply <= 1'b0;
    for (k = 0; k < 200 && sys_rst_n !== 1'b1; k++)
      #10;
    chk({7'h00, sys_rst_n}, 8'h01);
  endtask : expect_rst
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // --------
  // tests
  // --------
  initial
  begin
    repeat (5) @(posedge ref_clk);
    chk({6'h00, port_init, sys_rst_n}, 8'h02);
    rst_n <= 1'b1;
    expect_rst(1, 1'b1);
    rdc(`WRC_OFF_WDT_CTRL, 8'h53);
    rdc(`WRC_OFF_NOISE_KEY, 8'h55);
    rdc(`WRC_OFF_BOR_LEVEL, 8'h55);
    rdc(`WRC_OFF_CAUSE, 8'h00);
    rdc(4'hf, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 4; i++)
    begin
      wr(`WRC_OFF_BOR_LEVEL, bor_codes[i]);
      rdc(`WRC_OFF_BOR_LEVEL, bor_codes[i]);
      chk({6'h00, bor_threshold}, 8'(i));
    end
    wr(`WRC_OFF_NOISE_KEY, 8'haa);
    wr(`WRC_OFF_NOISE_KEY, 8'h55);
    wr(`WRC_OFF_WDT_CTRL, 8'ha8);
    wr(`WRC_OFF_WDT_CTRL, 8'h50);
    expect_rst(3000, 1'b0);
    $display("test valid keys and clearing done");
    kick_en <= 1'b0;
    expect_rst(1200, 1'b1);
    chk({7'h00, wdt_expired}, 8'h01);
    wr(`WRC_OFF_WDT_CTRL, 8'h50);
    expect_rst(900, 1'b0);
    expect_rst(300, 1'b1);
    wr(`WRC_OFF_WDT_CTRL, 8'h50);
    kick_en <= 1'b1;
    repeat (700) @(posedge ref_clk);
    #1 chk({7'h00, wdt_expired}, 8'h00);
    $display("test overflow done");
    kick_en  <= 1'b0;
    halt_req <= 1'b1;
    @(posedge ref_clk);
    halt_req <= 1'b0;
    rdc(`WRC_OFF_MODE, 8'h01);
    low_supply <= 1'b1;
    expect_rst(100, 1'b0);
    low_supply <= 1'b0;
    for (int k = 0; k < 1200 && pc_sp_clear !== 1'b1; k++)
      #10;
    chk({7'h00, pc_sp_clear}, 8'h01);
    rdc(`WRC_OFF_CAUSE, 8'h00);
    kick_en <= 1'b1;
    $display("test sleep overflow done");
    wr(`WRC_OFF_BOR_LEVEL, 8'h99);
    low_supply <= 1'b1;
    expect_rst(20, 1'b0);
    low_supply <= 1'b0;
    // a one-cycle dip never passes the agreeing sync stages; hold it longer
    repeat (4) @(posedge ref_clk);
    low_supply <= 1'b1;
    expect_rst(30, 1'b0);
    expect_rst(30, 1'b1);
    rdc(`WRC_OFF_CAUSE, 8'h04);
    rdc(`WRC_OFF_BOR_LEVEL, 8'h99);
    wr(`WRC_OFF_CAUSE, 8'h00);
    rdc(`WRC_OFF_CAUSE, 8'h00);
    $display("test brownout done");
    for (int i = 0; i < 3; i++)
    begin
      wr(bad_addr[i], bad_data[i]);
      expect_rst(12, 1'b0);
      expect_rst(60, 1'b1);
      rdc(bad_addr[i], bad_rest[i]);
      rdc(`WRC_OFF_CAUSE, bad_flag[i]);
      wr(`WRC_OFF_CAUSE, 8'h00);
      rdc(`WRC_OFF_CAUSE, 8'h00);
    end
    $display("test bad keys done");
    wr(`WRC_OFF_FLASH_CTL2, 8'h54);
    expect_rst(20, 1'b0);
    wr(`WRC_OFF_FLASH_CTL2, 8'h55);
    expect_rst(20, 1'b1);
    $display("test flash reset done");
    end_of_test();
  end
  initial
  begin
    #500us;
    fails++;
    $display("MISMATCH %0t watchdog timeout", $time);
    end_of_test();
  end
endmodule : watchdog_and_reset_control_test
`default_nettype wire

// *** testbench/wrc_core_model.sv ***
// processor core stand-in issuing clear and halt instructions
`timescale 1ns/1ps
`default_nettype none
module wrc_core_model #(
  parameter int unsigned KICK_GAP = 600
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic core_run,
  input  wire logic kick_en,
  input  wire logic halt_req,
  output logic      clear_watchdog_instruction_instr,
  output logic      halt_instr
);
  int unsigned gap_q;
  // core executes nothing while held in reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap_q         <= '0;
      clear_watchdog_instruction_instr <= 1'b0;
      halt_instr    <= 1'b0;
    end
    else
    begin
      gap_q         <= (gap_q == KICK_GAP) ? '0 : gap_q + 1;
      clear_watchdog_instruction_instr <= core_run && kick_en && gap_q == KICK_GAP;
      halt_instr    <= core_run && halt_req;
    end
  end
endmodule : wrc_core_model
`default_nettype wire

// *** testbench/wrc_monitor.sv ***
// port checker for the watchdog and reset control block
`timescale 1ns/1ps
`default_nettype none
`include "wrc_consts.svh"
module wrc_monitor (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       clear_watchdog_instruction_instr,
  input wire logic       sys_rst_n,
  input wire logic       pc_sp_clear,
  input wire logic       wdt_expired,
  input wire logic [1:0] bor_threshold
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // --------
  // assertions
  // --------
  wire logic wr_ctl = reg_wr && reg_addr == `WRC_OFF_WDT_CTRL;
  wire logic wr_key = reg_wr && reg_addr == `WRC_OFF_NOISE_KEY;
  wire logic bad_wk = reg_wdata[7:3] != `WRC_WDT_KEY_A &&
                      reg_wdata[7:3] != `WRC_WDT_KEY_B;
  AST_UPPER_ZERO: assert property (
    $past(reg_rd) && $past(reg_addr) == `WRC_OFF_CAUSE |-> reg_rdata[7:4] == 0)
    else $error("cause register upper bits not zero");
  AST_FLASH_RST: assert property (
    reg_wr && reg_addr == `WRC_OFF_FLASH_CTL2 && reg_wdata == 8'h55
    |-> ##[1:4] !sys_rst_n) else $error("flash control write gave no reset");
  AST_BOR_CODE: assert property (
    reg_wr && reg_addr == `WRC_OFF_BOR_LEVEL && reg_wdata == 8'h33
    |-> ##[1:3] bor_threshold == 2'h1) else $error("threshold not 2.55V");
  AST_HOLD: assert property ($fell(sys_rst_n) |-> !sys_rst_n[*8])
    else $error("internal reset too short");
  AST_SLEEP_PULSE: assert property (
    pc_sp_clear |-> sys_rst_n ##1 (!pc_sp_clear && wdt_expired))
    else $error("sleep overflow pulse wrong");
  AST_CLR_EXP: assert property (
    clear_watchdog_instruction_instr && sys_rst_n |-> ##[1:2] !wdt_expired)
    else $error("expired flag not cleared");
  AST_NOISE_OK: assert property (
    wr_key && sys_rst_n && (reg_wdata == 8'h55 || reg_wdata == 8'haa)
    |=> sys_rst_n[*8]) else $error("valid noise key caused reset");
  AST_KEY_DELAY: assert property (
    wr_ctl && bad_wk && sys_rst_n |=> sys_rst_n[*8])
    else $error("bad key reset came before its delay");
  cover property (pc_sp_clear);
  cover property ($fell(sys_rst_n));
  cover property ($rose(wdt_expired));
endmodule : wrc_monitor

bind wrc_top wrc_monitor i_wrc_monitor (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .clear_watchdog_instruction_instr(clear_watchdog_instruction_instr),
  .sys_rst_n(sys_rst_n), .pc_sp_clear(pc_sp_clear),
  .wdt_expired(wdt_expired), .bor_threshold(bor_threshold));
`default_nettype wire
